// *** verilog/pulse_prog_pkg.sv ***
// Package for the pulse-count voltage programmer: codes, timing, state types.
// Assumes a single 10 MHz clock; the programmer and its bench import this package, the host model does not.
package pulse_prog_pkg;
    localparam int unsigned CLK_HZ           = 10_000_000;
    // Falling-edge glitch filter: a low must last this long to count
    localparam int unsigned FILTER_NS        = 500;
    localparam int unsigned FILTER_CYC_RAW   = (FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned FILTER_CYC       = (FILTER_CYC_RAW < 1) ? 1 : FILTER_CYC_RAW;
    // Wire held high this long after a pulse marks the stop condition
    localparam int unsigned STOP_US          = 100;
    localparam int unsigned STOP_CYC         = STOP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W            = 12;
    localparam logic [4:0]  CODE_MAX         = 5'h1F;
    localparam logic [4:0]  CODE_DEFAULT     = 5'h06;
    localparam logic [5:0]  PULSE_LIMIT      = 6'h1F;
    // Target in millivolts magnitude: count 1 is 5400 mV, steps of 100 mV
    localparam logic [12:0] LEVEL_BASE_MV    = 13'h1518;
    localparam logic [12:0] LEVEL_STEP_MV    = 13'h0064;
    // Magnitude at the default count 6, also the reset value
    localparam logic [12:0] LEVEL_DEFAULT_MV = 13'h1324;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b001,
        ST_DEFAULT = 3'b010,
        ST_PROGRAM = 3'b100
    } mode_type;

    typedef struct packed {
        logic        regulate;
        logic        discharge;
        logic [4:0]  code;
        logic [12:0] level_mv;
    } power_ctrl_type;
endpackage

// *** verilog/pulse_count_voltage_programmer.sv ***
// Pulse-count programmer: filters the programming wire, counts pulses,
// and selects the negative output level, run mode and discharge control.
// Assumes pins synchronous to clk_in; the analog stages act on the outputs.
`timescale 1ns/1ps
// Summary of operation
// - pulse counts 1 to 31 select -5.4 V upward to -2.4 V.
// - each count step moves the negative target by 100 mV.
// - run-control high forces default count 6 (-4.9 V), wire ignored.
// - run-control low: wire low is off, wire high runs programmed level.
// - a transfer is framed by start and stop conditions.
// - data flows in one direction only, host to programmer; nothing drives the wire back.
// - short lows on the wire are filtered and not counted.
// - discharge-select low enables discharge after shutdown; high disables it.
// - discharge depends only on discharge-select, not on run control.
// - run-control falling stops switching and enters shutdown.
module pulse_count_voltage_programmer
    import pulse_prog_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = FILTER_CYC,
    parameter int unsigned STOP_CYCLES   = STOP_CYC
) (
    input  wire logic           clk_in,
    input  wire logic           rst_b_in,
    input  wire logic           run_control_in,
    input  wire logic           pulse_program_wire_in,
    input  wire logic           output_discharge_select_in,
    output power_ctrl_type      power_ctrl_out,
    output mode_type            mode_out
);

    ////////////////////////////////////////////////////////////////////////
    // Both counters are CNT_W wide; larger timing values would wrap silently
    if (FILTER_CYCLES < 1 || FILTER_CYCLES >= (1 << CNT_W)) begin : g_bad_filter
        $error("pulse_count_voltage_programmer: FILTER_CYCLES out of range");
    end
    // Stop must outlast the filter, or a slow pulse could close its own frame
    if (STOP_CYCLES <= FILTER_CYCLES || STOP_CYCLES >= (1 << CNT_W)) begin : g_bad_stop
        $error("pulse_count_voltage_programmer: STOP_CYCLES out of range");
    end

    // Last count of each run before the event fires
    localparam logic [CNT_W-1:0] FILTER_LAST = CNT_W'(FILTER_CYCLES - 1);
    localparam logic [CNT_W-1:0] STOP_LAST   = CNT_W'(STOP_CYCLES - 1);

    typedef struct packed {
        logic            wire_f;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] high_cnt;
        logic            in_frame;
        logic [5:0]      pulses;
        logic [4:0]      code;
        logic            run_d;
        mode_type        mode;
        power_ctrl_type  ctrl;
    } state_type;

    state_type state;
    state_type next_state;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       fall;
        logic [4:0] use_code;
        fall       = 1'b0;
        use_code   = CODE_DEFAULT;
        next_state = state;
        // The wire is only ever sampled here; nothing drives it back
        // Filtered level: a low counts only after it persists; highs pass at once
        if (pulse_program_wire_in) begin
            next_state.low_cnt = '0;
            next_state.wire_f  = 1'b1;
        end else if (state.low_cnt >= FILTER_LAST) begin
            next_state.wire_f = 1'b0;
            fall              = state.wire_f;
        end else begin
            next_state.low_cnt = state.low_cnt + 1'b1;
        end
        // Count falls inside a frame; stop is a long high after pulses
        // Gaps between pulses must stay shorter than STOP_CYCLES or the frame closes early
        if (fall) begin
            next_state.in_frame = 1'b1;
            next_state.high_cnt = '0;
            if (state.pulses <= PULSE_LIMIT) begin
                next_state.pulses = state.pulses + 1'b1;
            end
        end else if (state.in_frame && state.wire_f) begin
            if (state.high_cnt >= STOP_LAST) begin
                next_state.in_frame = 1'b0;
                next_state.pulses   = '0;
                if (state.pulses != '0 && state.pulses <= PULSE_LIMIT) begin
                    next_state.code = state.pulses[4:0];
                end
            end else begin
                next_state.high_cnt = state.high_cnt + 1'b1;
            end
        end
        // Programming only honoured while run control is low
        if (run_control_in) begin
            next_state.in_frame = 1'b0;
            next_state.pulses   = '0;
            // A frame that closes as run control rises is dropped as well
            next_state.code     = state.code;
        end
        // One-cycle memory of run control marks its falling edge
        next_state.run_d = run_control_in;
        // Mode selection from run control and filtered wire
        if (run_control_in) begin
            next_state.mode = ST_DEFAULT;
        end else if (state.run_d) begin
            next_state.mode = ST_OFF;
        end else if (state.wire_f) begin
            next_state.mode = ST_PROGRAM;
        end else begin
            next_state.mode = ST_OFF;
        end
        case (next_state.mode)
            ST_DEFAULT: use_code = CODE_DEFAULT;
            ST_PROGRAM: use_code = next_state.code;
            ST_OFF:     use_code = next_state.code;
            default:    use_code = CODE_DEFAULT;
        endcase
        next_state.ctrl.regulate  = (next_state.mode != ST_OFF);
        next_state.ctrl.code      = use_code;
        // Magnitude falls 100 mV per count from 5400 mV at count 1
        next_state.ctrl.level_mv  = LEVEL_BASE_MV -
            13'(LEVEL_STEP_MV * 13'(use_code - 5'h01));
        // Discharge only from its own pin; the analog side applies it in shutdown
        next_state.ctrl.discharge = ~output_discharge_select_in;
    end

    // Reset shows the default level so the outputs are sane before any frame
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state                <= '0;
            state.wire_f         <= 1'b0;
            state.code           <= CODE_DEFAULT;
            state.mode           <= ST_OFF;
            state.ctrl.code      <= CODE_DEFAULT;
            state.ctrl.level_mv  <= LEVEL_DEFAULT_MV;
        end else begin
            state <= next_state;
        end
    end

    assign power_ctrl_out = state.ctrl;
    assign mode_out       = state.mode;

    ////////////////////////////////////////////////////////////////////////
    // Checks run only out of reset
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    level_map_a: assert property (
        power_ctrl_out.level_mv == LEVEL_BASE_MV - 13'(LEVEL_STEP_MV * 13'(power_ctrl_out.code - 5'h01)))
        else $error("level does not match code");

    step_size_a: assert property (
        $changed(power_ctrl_out.code)
        |-> 13'($past(power_ctrl_out.level_mv) - power_ctrl_out.level_mv) ==
            13'(LEVEL_STEP_MV * 13'(13'(power_ctrl_out.code) - 13'($past(power_ctrl_out.code)))))
        else $error("level change is not a whole number of steps");
    default_run_a: assert property (
        run_control_in |=> mode_out == ST_DEFAULT && power_ctrl_out.code == CODE_DEFAULT
            && power_ctrl_out.level_mv == LEVEL_DEFAULT_MV)
        else $error("default level not applied");
    off_mode_a: assert property (
        !run_control_in && !$past(run_control_in) && !state.wire_f |=> mode_out == ST_OFF)
        else $error("device not off");
    shutdown_fall_a: assert property (
        $fell(run_control_in) |=> !power_ctrl_out.regulate)
        else $error("no shutdown on run-control fall");

    glitch_reject_a: assert property (
        $fell(state.wire_f)
        |-> !$past(pulse_program_wire_in) && (FILTER_CYCLES < 2 || !$past(pulse_program_wire_in, 2)))
        else $error("filtered wire fell on a short low");
    discharge_pin_a: assert property (
        ##1 power_ctrl_out.discharge == !$past(output_discharge_select_in))
        else $error("discharge not following select pin");

    apply_stop_a: assert property (
        state.pulses > PULSE_LIMIT |=> state.code == $past(state.code))
        else $error("overlong frame changed setting");

    ////////////////////////////////////////////////////////////////////////
    mode_onehot_a: assert property (
        $onehot(mode_out) && power_ctrl_out.regulate == (mode_out != ST_OFF))
        else $error("mode not one-hot or regulate disagrees");

    program_mode_a: assert property (
        !run_control_in && !$past(run_control_in) && state.wire_f
        |=> mode_out == ST_PROGRAM)
        else $error("programmed level not running");

    // Count 31 gives the smallest magnitude, count 1 the largest
    level_range_a: assert property (
        power_ctrl_out.code != 5'h00 && power_ctrl_out.level_mv <= LEVEL_BASE_MV &&
        power_ctrl_out.level_mv >= 13'(LEVEL_BASE_MV - LEVEL_STEP_MV * 13'(CODE_MAX - 5'h01)))
        else $error("target outside the programmable range");

    wire_ignored_a: assert property (
        run_control_in
        |=> state.code == $past(state.code) && state.pulses == 6'h00)
        else $error("wire acted on while run control high");

    frame_open_a: assert property (
        $fell(state.wire_f) && !$past(run_control_in)
        |-> state.in_frame && state.pulses != 6'h00)
        else $error("counted fall did not open a frame");

    stop_apply_a: assert property (
        state.in_frame && state.wire_f && pulse_program_wire_in && !run_control_in &&
        state.high_cnt >= STOP_LAST && state.pulses != 6'h00 && state.pulses <= PULSE_LIMIT
        |=> !state.in_frame && state.code == $past(state.pulses[4:0]))
        else $error("completed frame not applied");

    highs_pass_a: assert property (
        pulse_program_wire_in |=> state.wire_f)
        else $error("high on the wire was delayed by the filter");
endmodule

// *** bench/host_wire_model.sv ***
// Host model: drives the programming wire with framed pulse trains.
// Assumes the bench calls its tasks; the wire idles high between frames.
`timescale 1ns/1ps
module host_wire_model #(
    parameter int STOP = 20
) (
    input  wire logic clk_in,
    output logic      wire_out
);
    initial wire_out = 1'b1;
    task automatic hold(input logic v);
        @(negedge clk_in) wire_out = v;
    endtask
    // A 40-cycle high after each pulse keeps the rate under 250 kHz
    task automatic send(input int n, input int len);
        repeat (n) begin // Only the host drives the wire
            hold(1'b0);
            repeat (len - 1) @(negedge clk_in);
            hold(1'b1);
            repeat (39) @(negedge clk_in);
        end
        repeat (STOP + 3) @(negedge clk_in); // Stop condition
    endtask
endmodule

// *** bench/tb_pulse_count_voltage_programmer.sv ***
// Bench for the pulse-count programmer with shortened filter and stop counts.
// Assumes the host model owns the wire; other pins change on falling edges.
`timescale 1ns/1ps
module tb_pulse_count_voltage_programmer;
    import pulse_prog_pkg::*;
    logic           clk_in = 1'b0;
    logic           rst_b_in = 1'b0;
    logic           run_control_in = 1'b0;
    logic           output_discharge_select_in = 1'b1;
    logic           pulse_program_wire_in;
    power_ctrl_type power_ctrl_out;
    mode_type       mode_out;
    int             n_errors = 0;
    int             checked = 0;
    int             codes[3] = '{1, 31, 17};
    // Longer than the 40-cycle gap between pulses, so only the tail closes a frame
    localparam int  STOP_T = 60;
    always #50 clk_in = ~clk_in;
    host_wire_model #(.STOP(STOP_T)) i_host (.clk_in(clk_in), .wire_out(pulse_program_wire_in));
    pulse_count_voltage_programmer #(.FILTER_CYCLES(2), .STOP_CYCLES(STOP_T)) i_dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .run_control_in(run_control_in),
        .pulse_program_wire_in(pulse_program_wire_in),
        .output_discharge_select_in(output_discharge_select_in),
        .power_ctrl_out(power_ctrl_out), .mode_out(mode_out));
    ////////////////////////////////////////////////////////////////////////////
    function automatic power_ctrl_type ctl(input logic r, input logic d, input logic [4:0] c);
        ctl = {r, d, c, 13'(LEVEL_BASE_MV - LEVEL_STEP_MV * (13'(c) - 13'h0001))};
    endfunction
    task automatic chk_ctrl(input power_ctrl_type exp, input logic [20:0] m);
        checked++;
        if ((power_ctrl_out & m) !== (exp & m)) begin
            n_errors++;
            $display("ERROR %0t ctrl %h exp %h", $time, power_ctrl_out, exp);
        end
    endtask
    task automatic chk_mode(input mode_type exp);
        checked++;
        if (mode_out !== exp) begin
            n_errors++;
            $display("ERROR %0t mode %b exp %b", $time, mode_out, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Run stays low throughout every frame
    task automatic t_program;
        foreach (codes[i]) begin
            i_host.send(codes[i], 3);
            chk_ctrl(ctl(1'b1, 1'b0, codes[i][4:0]), 21'h1FFFFF);
            chk_mode(ST_PROGRAM);
        end
        $display("t_program done");
    endtask
    task automatic t_reject;
        i_host.send(1, 1);
        chk_ctrl(ctl(1'b1, 1'b0, 5'h11), 21'h1FFFFF);
        i_host.send(32, 3);
        chk_ctrl(ctl(1'b1, 1'b0, 5'h11), 21'h1FFFFF);
        $display("t_reject done");
    endtask
    task automatic t_enable;
        @(negedge clk_in) run_control_in = 1'b1;
        i_host.hold(1'b0);
        repeat (4) @(negedge clk_in);
        chk_ctrl(ctl(1'b1, 1'b0, 5'h06), 21'h1FFFFF);
        chk_mode(ST_DEFAULT);
        output_discharge_select_in = 1'b0;
        repeat (2) @(negedge clk_in);
        chk_ctrl(ctl(1'b1, 1'b1, 5'h06), 21'h1FFFFF);
        run_control_in = 1'b0;
        @(negedge clk_in);
        chk_mode(ST_OFF);
        repeat (5) @(negedge clk_in);
        chk_mode(ST_OFF);
        chk_ctrl(ctl(1'b0, 1'b1, 5'h06), 21'h180000);
        output_discharge_select_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk_ctrl(ctl(1'b0, 1'b0, 5'h06), 21'h180000);
        $display("t_enable done");
    endtask
    // Run falls with the wire high: one cycle off, then the kept code runs
    task automatic t_shutdown;
        @(negedge clk_in) run_control_in = 1'b1;
        i_host.hold(1'b1);
        repeat (3) @(negedge clk_in);
        chk_mode(ST_DEFAULT);
        run_control_in = 1'b0;
        @(negedge clk_in);
        chk_mode(ST_OFF);
        chk_ctrl(ctl(1'b0, 1'b0, 5'h06), 21'h100000);
        @(negedge clk_in);
        chk_mode(ST_PROGRAM);
        chk_ctrl(ctl(1'b1, 1'b0, 5'h11), 21'h1FFFFF);
        $display("t_shutdown done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clk_in);
        chk_ctrl(ctl(1'b0, 1'b0, 5'h06), 21'h1FFFFF);
        chk_mode(ST_OFF);
        rst_b_in = 1'b1;
        repeat (3) @(negedge clk_in);
        t_program();
        t_reject();
        t_enable();
        t_shutdown();
        tally_and_finish();
    end
    // A hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        tally_and_finish();
    end
endmodule
